// ==== verilog/txd_top.v ====
// transmit offload data descriptor decoder, fetcher and delay timer
`timescale 1ns/1ns
`include "txd_consts.vh"
module txd_top #(
  parameter DLY_W = 16,
  parameter TICK_CYC = (`TXD_TICK_NS + `TXD_CLK_NS - 1) / `TXD_CLK_NS
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // descriptor in
  input wire desc_valid,
  output wire desc_ready,
  input wire [127:0] desc_data,
  // buffer read master
  output wire rd_req,
  output reg [63:0] rd_addr,
  input wire rd_ack,
  input wire [31:0] rd_data,
  // frame stream out
  output wire tx_valid,
  input wire tx_ready,
  output reg [31:0] tx_data,
  output reg [2:0] tx_bytes,
  output reg tx_first,
  output reg tx_last,
  output reg tx_vlan_insert,
  output reg [31:0] tx_vlan_word,
  output reg tx_fcs_append,
  output reg [7:0] tx_packet_option,
  output reg tx_segmentation,
  // status write-back
  output wire wb_valid,
  input wire wb_ready,
  output reg [3:0] wb_status,
  // interrupt
  output wire irq
);
  localparam S_IDLE = 2'd0;
  localparam S_RD = 2'd1;
  localparam S_TX = 2'd2;
  localparam S_WB = 2'd3;
  // a read word carries four bytes; a short word only ends a buffer
  localparam [`TXD_LEN_W-1:0] WORD_LEN = `TXD_WORD_BYTES;
  localparam [`TXD_ADDR_W-1:0] WORD_STEP = `TXD_WORD_BYTES;

  reg [1:0] state;
  reg global_vlan_mode_enable;
  reg [DLY_W-1:0] delay_value_field;
  reg [15:0] vlan_ethertype_register;
  reg [2:0] int_stat;
  reg [2:0] int_mask;
  reg [`TXD_LEN_W-1:0] remain;
  reg [7:0] descriptor_command_byte;
  reg in_pkt;
  reg first_word;
  reg [DLY_W-1:0] countdown;
  reg count_run;
  reg [15:0] tick_cnt;

  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [`TXD_LEN_W-1:0] buffer_byte_length = desc_data[`TXD_LEN_LSB +: `TXD_LEN_W];
  wire [3:0] descriptor_type_code = desc_data[`TXD_TYP_LSB +: 4];
  wire [7:0] cmd_in = desc_data[`TXD_CMD_LSB +: 8];
  wire [7:0] packet_option_field = desc_data[`TXD_OPT_LSB +: 8];
  wire [15:0] vlan_special = desc_data[`TXD_VLAN_LSB +: 16];
  wire end_of_packet_bit = cmd_in[`TXD_C_EOP];
  wire segmentation_enable_bit = cmd_in[`TXD_C_TSE];
  wire vlan_insert_enable = cmd_in[`TXD_C_VLE];
  wire fcs_insert_bit = cmd_in[`TXD_C_FCS_INSERT_BIT];
  wire report_status_bit = descriptor_command_byte[`TXD_C_RS];
  wire interrupt_delay_enable = descriptor_command_byte[`TXD_C_IDE];
  wire take = (state == S_IDLE) && desc_valid;
  wire fmt_ok = cmd_in[`TXD_C_EXT] && (descriptor_type_code == `TXD_TYPE_DATA);
  // segmentation frame attrs ride on first, normal on last
  wire attr_here = segmentation_enable_bit ? !in_pkt : end_of_packet_bit;
  wire desc_end = (state == S_TX) && tx_ready && (remain == {`TXD_LEN_W{1'b0}});
  wire wb_done = (state == S_WB) && wb_ready;
  wire desc_fin = (desc_end && !report_status_bit) || wb_done;
  wire tick = (tick_cnt == 16'h0000);
  wire cnt_zero = count_run && tick && (countdown <= {{(DLY_W-1){1'b0}}, 1'b1});
  // event vector for the sticky status bits
  wire [2:0] ev_set;
  // a refused descriptor is flagged, never fetched
  assign ev_set[`TXD_I_BAD] = take && !fmt_ok;
  assign ev_set[`TXD_I_WB] = wb_done;
  // timer expiry; immediate on plain report
  assign ev_set[`TXD_I_TXINT] = cnt_zero || (wb_done && !interrupt_delay_enable);

  // decode of the mapped register offsets

  function is_addr;
    input [11:0] a;
    begin
      is_addr = (a == `TXD_A_CTRL) || (a == `TXD_A_DLY) || (a == `TXD_A_VET) ||
        (a == `TXD_A_IST) || (a == `TXD_A_IMSK) || (a == `TXD_A_STAT);
    end
  endfunction

  // zero wait states; unmapped address answers with an error
  assign pready = 1'b1;
  assign pslverr = acc && !is_addr(paddr);
  assign desc_ready = (state == S_IDLE);
  assign rd_req = (state == S_RD);
  assign tx_valid = (state == S_TX);
  assign wb_valid = (state == S_WB);
  assign irq = |(int_stat & int_mask);

  // read data latched in setup so it stands through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `TXD_A_CTRL: prdata <= {31'h0000_0000, global_vlan_mode_enable};
        `TXD_A_DLY: prdata <= {{(32-DLY_W){1'b0}}, delay_value_field};
        `TXD_A_VET: prdata <= {16'h0000, vlan_ethertype_register};
        `TXD_A_IST: prdata <= {29'h0000_0000, int_stat};
        `TXD_A_IMSK: prdata <= {29'h0000_0000, int_mask};
        `TXD_A_STAT: prdata <= {count_run, in_pkt, state, {(28-DLY_W){1'b0}}, countdown};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_vlan_mode_enable <= 1'b0;
      delay_value_field <= {DLY_W{1'b0}};
      vlan_ethertype_register <= `TXD_VET_RST;
      int_mask <= 3'h0;
    end else if (wr) begin
      if (paddr == `TXD_A_CTRL)
        global_vlan_mode_enable <= pwdata[0];
      if (paddr == `TXD_A_DLY)
        delay_value_field <= pwdata[DLY_W-1:0];
      if (paddr == `TXD_A_VET)
        vlan_ethertype_register <= pwdata[15:0];
      if (paddr == `TXD_A_IMSK)
        int_mask <= pwdata[2:0];
    end
  end

  // sticky events; a set in the clearing cycle survives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= 3'h0;
    end else begin
      int_stat <= (int_stat & ~((wr && paddr == `TXD_A_IST) ? pwdata[2:0] : 3'h0)) | ev_set;
    end
  end

  // time base divider for the delay counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt <= 16'h0000;
    else if (tick)
      tick_cnt <= TICK_CYC[15:0] - 16'h0001;
    else
      tick_cnt <= tick_cnt - 16'h0001;
  end

  // a reload in the expiry cycle still raises the expiry interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      countdown <= {DLY_W{1'b0}};
      count_run <= 1'b0;
    end else if (desc_fin && interrupt_delay_enable) begin
      countdown <= delay_value_field;
      count_run <= 1'b1;
    end else if (wb_done) begin
      countdown <= {DLY_W{1'b0}};
      count_run <= 1'b0;
    end else if (cnt_zero) begin
      countdown <= {DLY_W{1'b0}};
      count_run <= 1'b0;
    end else if (count_run && tick) begin
      countdown <= countdown - {{(DLY_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      rd_addr <= 64'h0000_0000_0000_0000;
      remain <= {`TXD_LEN_W{1'b0}};
      descriptor_command_byte <= 8'h00;
      in_pkt <= 1'b0;
      first_word <= 1'b0;
      tx_data <= 32'h0000_0000;
      tx_bytes <= 3'h0;
      tx_first <= 1'b0;
      tx_last <= 1'b0;
      tx_vlan_insert <= 1'b0;
      tx_vlan_word <= 32'h0000_0000;
      tx_fcs_append <= 1'b0;
      tx_packet_option <= 8'h00;
      tx_segmentation <= 1'b0;
      wb_status <= 4'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (desc_valid && fmt_ok) begin
            rd_addr <= desc_data[`TXD_ADDR_LSB +: `TXD_ADDR_W];
            remain <= buffer_byte_length;
            descriptor_command_byte <= cmd_in;
            first_word <= !in_pkt;
            tx_segmentation <= segmentation_enable_bit;
            // options only from the first descriptor
            if (!in_pkt)
              tx_packet_option <= packet_option_field;
            // vlan evaluated on the end descriptor, or on the first one under segmentation
            if (attr_here) begin
              // tag only with global mode on
              tx_vlan_insert <= vlan_insert_enable && global_vlan_mode_enable;
              tx_vlan_word <= {vlan_ethertype_register, vlan_special};
              // crc forced by tag, else by fcs bit
              tx_fcs_append <= (vlan_insert_enable && global_vlan_mode_enable) || fcs_insert_bit;
            end
            // packet closes on the end descriptor
            in_pkt <= !end_of_packet_bit;
            state <= (buffer_byte_length == {`TXD_LEN_W{1'b0}}) ? S_TX : S_RD;
            tx_bytes <= 3'h0;
            tx_last <= end_of_packet_bit && (buffer_byte_length == {`TXD_LEN_W{1'b0}});
            tx_first <= !in_pkt;
          end
        end
        S_RD: begin
          // one word at a time, descriptor order
          if (rd_ack) begin
            tx_data <= rd_data;
            tx_first <= first_word;
            first_word <= 1'b0;
            if (remain > WORD_LEN) begin
              tx_bytes <= WORD_LEN[2:0];
              remain <= remain - WORD_LEN;
              tx_last <= 1'b0;
            end else begin
              tx_bytes <= remain[2:0];
              remain <= {`TXD_LEN_W{1'b0}};
              tx_last <= descriptor_command_byte[`TXD_C_EOP];
            end
            rd_addr <= rd_addr + WORD_STEP;
            state <= S_TX;
          end
        end
        S_TX: begin
          if (tx_ready) begin
            if (remain != {`TXD_LEN_W{1'b0}})
              state <= S_RD;
            else if (report_status_bit)
              state <= S_WB;
            else
              state <= S_IDLE;
            wb_status <= `TXD_ST_DONE;
          end
        end
        S_WB: begin
          if (wb_ready)
            state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== verilog/txd_consts.vh ====
// constants for the transmit offload data descriptor engine
`ifndef TXD_CONSTS_VH
`define TXD_CONSTS_VH
`define TXD_A_CTRL 12'h000
`define TXD_A_DLY 12'h004
`define TXD_A_VET 12'h008
`define TXD_A_IST 12'h00c
`define TXD_A_IMSK 12'h010
`define TXD_A_STAT 12'h014
`define TXD_VET_RST 16'h8100
`define TXD_TYPE_DATA 4'h1
`define TXD_LEN_LSB 64
`define TXD_LEN_W 20
`define TXD_ADDR_LSB 0
`define TXD_ADDR_W 64
`define TXD_WORD_BYTES 4
`define TXD_TYP_LSB 84
`define TXD_CMD_LSB 88
`define TXD_OPT_LSB 104
`define TXD_VLAN_LSB 112
`define TXD_C_EOP 0
`define TXD_C_FCS_INSERT_BIT 1
`define TXD_C_TSE 2
`define TXD_C_RS 3
`define TXD_C_EXT 5
`define TXD_C_VLE 6
`define TXD_C_IDE 7
`define TXD_ST_DONE 4'h1
`define TXD_I_TXINT 0
`define TXD_I_WB 1
`define TXD_I_BAD 2
`define TXD_TICK_NS 1024
`define TXD_CLK_NS 50
`endif

// ==== verification/txd_chk_asserts.sv ====
// port assertions for the descriptor engine
`timescale 1ns/1ns
module txd_chk (
  // clock, reset and descriptor side
  input wire pclk,
  input wire presetn,
  input wire desc_valid,
  input wire desc_ready,
  input wire [127:0] desc_data,
  input wire rd_req,
  input wire [63:0] rd_addr,
  input wire rd_ack,
  // frame and write-back side
  input wire tx_valid,
  input wire tx_ready,
  input wire tx_vlan_insert,
  input wire tx_fcs_append,
  input wire wb_valid,
  input wire wb_ready,
  input wire [3:0] wb_status
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire fmt_ok = desc_data[93] && desc_data[87:84] == 4'h1;
  sequence s_take_good;
    desc_valid && desc_ready && fmt_ok && desc_data[83:64] != 20'h0;
  endsequence
  sequence s_wb_wait;
    wb_valid && !wb_ready;
  endsequence
  chk_fetch_addr: assert property (s_take_good |=> rd_req && rd_addr == $past(desc_data[63:0]))
    else $error("read not at buffer address");
  chk_bad_drop: assert property (desc_valid && desc_ready && !fmt_ok |=> !rd_req && !wb_valid)
    else $error("bad descriptor processed");
  chk_read_hold: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr))
    else $error("read dropped early");
  chk_frame_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_vlan_insert))
    else $error("frame word dropped early");
  chk_vlan_fcs: assert property (tx_valid && tx_vlan_insert |-> tx_fcs_append)
    else $error("tagged frame lacks fcs");
  chk_wb_done: assert property (wb_valid |-> wb_status == 4'h1)
    else $error("status not done");
  chk_wb_hold: assert property (s_wb_wait |=> wb_valid && $stable(wb_status))
    else $error("write-back dropped early");
  chk_desc_busy: assert property (s_take_good |=> !desc_ready [*2])
    else $error("descriptor taken while busy");
endmodule
bind txd_top txd_chk txd_chk_inst (.pclk(pclk), .presetn(presetn), .desc_valid(desc_valid),
  .desc_ready(desc_ready), .desc_data(desc_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_vlan_insert(tx_vlan_insert), .tx_fcs_append(tx_fcs_append),
  .wb_valid(wb_valid), .wb_ready(wb_ready), .wb_status(wb_status));

// ==== verification/txd_host.sv ====
// host memory model answering buffer reads and write-backs
`timescale 1ns/1ns
module txd_host (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // buffer reads and write-back
  input wire rd_req,
  input wire [63:0] rd_addr,
  output reg rd_ack,
  output reg [31:0] rd_data,
  input wire wb_valid,
  output reg wb_ready
);
  reg ph;
  wire [7:0] a = rd_addr[7:0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ack <= 1'b0;
      rd_data <= 32'h0;
      wb_ready <= 1'b0;
      ph <= 1'b0;
    end else begin
      ph <= !ph;
      rd_ack <= 1'b0;
      // released data bus inverts every cycle, never holding the last word
      rd_data <= ~rd_data;
      wb_ready <= wb_valid && !wb_ready;
      // each byte holds its own low address
      if (rd_req && !rd_ack && ph) begin
        rd_ack <= 1'b1;
        rd_data <= {a + 8'h3, a + 8'h2, a + 8'h1, a};
      end
    end
  end
endmodule

// ==== verification/txd_top_bench.sv ====
// bench for the descriptor engine
`timescale 1ns/1ns
`include "txd_consts.vh"
module txd_top_bench;
  logic pclk, presetn, psel, penable, pwrite, desc_valid, rerr, tx_ready = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  logic [127:0] desc_data;
  logic [7:0] byq[$];
  logic [42:0] attr;
  int n_mismatch, checks, nwb, nfirst;
  wire [31:0] prdata, rd_data, tx_data, tx_vlan_word;
  wire pready, pslverr, desc_ready, rd_req, rd_ack, tx_valid, tx_last, tx_vlan_insert, tx_fcs_append;
  wire wb_valid, wb_ready, irq;
  wire [63:0] rd_addr;
  wire [2:0] tx_bytes;
  wire [7:0] tx_packet_option;
  wire [3:0] wb_status;
  wire tx_first, tx_segmentation;
  txd_top #(.TICK_CYC(1)) txd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .desc_valid(desc_valid), .desc_ready(desc_ready), .desc_data(desc_data), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_bytes(tx_bytes), .tx_first(tx_first), .tx_last(tx_last),
    .tx_vlan_insert(tx_vlan_insert), .tx_vlan_word(tx_vlan_word), .tx_fcs_append(tx_fcs_append),
    .tx_packet_option(tx_packet_option), .tx_segmentation(tx_segmentation), .wb_valid(wb_valid),
    .wb_ready(wb_ready), .wb_status(wb_status), .irq(irq));
  txd_host txd_host_inst (.pclk(pclk), .presetn(presetn), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data), .wb_valid(wb_valid), .wb_ready(wb_ready));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tx_ready <= presetn && !tx_ready;
    if (tx_valid && tx_ready) begin
      for (int i = 0; i < tx_bytes; i++)
        byq.push_back(tx_data[8*i+:8]);
      if (tx_first)
        nfirst <= nfirst + 1;
      if (tx_last)
        attr <= {tx_segmentation, tx_vlan_insert, tx_fcs_append, tx_packet_option, tx_vlan_word};
    end
    if (wb_valid && wb_ready)
      nwb <= nwb + 1;
  end
  task chk(input string s, input logic [63:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task chk_irq(input logic e);
    @(negedge pclk);
    chk("irq", e, irq);
  endtask
  function automatic logic [127:0] mk(input logic [63:0] a, input logic [19:0] n, input logic [7:0] c, o,
    input logic [15:0] v);
    return {v, o, 8'h0, c, `TXD_TYPE_DATA, n, a};
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task send(input logic [127:0] d);
    @(posedge pclk);
    desc_data <= d;
    desc_valid <= 1'b1;
    @(posedge pclk);
    while (desc_ready !== 1'b1) @(posedge pclk);
    desc_valid <= 1'b0;
    desc_data <= ~d;
  endtask
  task wait_wb;
    int n0;
    n0 = nwb;
    while (nwb == n0) @(negedge pclk);
  endtask
  task t_regs;
    apb(1'b0, `TXD_A_VET, 32'h0);
    chk("ethertype", 32'h8100, rdat);
    apb(1'b0, 12'h20, 32'h0);
    chk("unmapped", 33'h1, {rdat, rerr});
    apb(1'b1, `TXD_A_IMSK, 32'h7);
    send(mk(64'h40, 20'h4, 8'h9, 8'h0, 16'h0));
    apb(1'b0, `TXD_A_IST, 32'h0);
    chk("bad format", 1'b1, rdat[2]);
    apb(1'b1, `TXD_A_IST, 32'h7);
    chk_irq(1'b0);
    $display("t_regs end");
  endtask
  task t_vlan;
    apb(1'b1, `TXD_A_CTRL, 32'h1);
    byq = {};
    send(mk(64'h1001, 20'h5, 8'h20, 8'ha5, 16'h1111));
    send(mk(64'h2002, 20'h3, 8'h69, 8'h3c, 16'h1234));
    wait_wb;
    chk("count", 8, byq.size());
    foreach (byq[i])
      chk("byte", i < 5 ? i + 1 : i - 3, byq[i]);
    chk("attrs", {3'b011, 8'ha5, 32'h8100_1234}, attr);
    chk("first flags", 1, nfirst);
    chk_irq(1'b1);
    apb(1'b0, `TXD_A_IST, 32'h0);
    chk("immediate irq", 1'b1, rdat[0]);
    apb(1'b1, `TXD_A_IST, 32'h7);
    $display("t_vlan end");
  endtask
  task t_ctx;
    send(mk(64'h30, 20'h2, 8'h60, 8'h0, 16'h2222));
    send(mk(64'h34, 20'h2, 8'h29, 8'h0, 16'h3333));
    wait_wb;
    chk("late vle", 2'b00, attr[41:40]);
    send(mk(64'h3c, 20'h2, 8'h66, 8'h0, 16'h5555));
    send(mk(64'h40, 20'h2, 8'h2d, 8'h0, 16'h6666));
    wait_wb;
    chk("seg attrs", {3'b111, 32'h8100_5555}, {attr[42:40], attr[31:0]});
    chk("first flags", 3, nfirst);
    apb(1'b1, `TXD_A_CTRL, 32'h0);
    send(mk(64'h38, 20'h1, 8'h6b, 8'h0, 16'h4444));
    wait_wb;
    chk("vlan off", 2'b01, attr[41:40]);
    $display("t_ctx end");
  endtask
  task t_delay;
    apb(1'b1, `TXD_A_IMSK, 32'h1);
    apb(1'b1, `TXD_A_DLY, 32'h28);
    apb(1'b1, `TXD_A_IST, 32'h7);
    send(mk(64'h50, 20'h1, 8'ha9, 8'h0, 16'h0));
    wait_wb;
    repeat (12) @(negedge pclk);
    chk_irq(1'b0);
    send(mk(64'h54, 20'h1, 8'ha9, 8'h0, 16'h0));
    wait_wb;
    repeat (25) @(negedge pclk);
    chk_irq(1'b0);
    repeat (25) @(negedge pclk);
    chk_irq(1'b1);
    apb(1'b1, `TXD_A_IMSK, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, `TXD_A_IST, 32'h7);
    apb(1'b1, `TXD_A_IMSK, 32'h1);
    chk_irq(1'b0);
    send(mk(64'h58, 20'h1, 8'ha9, 8'h0, 16'h0));
    wait_wb;
    send(mk(64'h5c, 20'h1, 8'h29, 8'h0, 16'h0));
    wait_wb;
    chk_irq(1'b1);
    apb(1'b0, `TXD_A_STAT, 32'h0);
    chk("timer cleared", 17'h0, {rdat[31], rdat[15:0]});
    apb(1'b1, `TXD_A_IST, 32'h7);
    repeat (50) @(negedge pclk);
    chk_irq(1'b0);
    $display("t_delay end");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    {psel, penable, pwrite, desc_valid, paddr, pwdata, desc_data} = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_vlan;
    t_ctx;
    t_delay;
    report_and_stop;
  end
endmodule
